// >>> verilog/supply_integrity_pkg.sv
// constants for the supply integrity monitor: register map, field positions,
// interrupt vector, threshold level codes and bus handshake states.
// assumes a 32-bit APB master and a 10 MHz cpu clock.
package supply_integrity_pkg;

   localparam int APB_AW = 12;
   localparam int APB_DW = 32;
   localparam int CSR_W = 8;

   // register index; the byte address is four times the index
   localparam logic [7:0] SUPPLY_CSR_IDX = 8'h3A;
   localparam logic [APB_AW-1:0] SUPPLY_CSR_ADDR = {2'h0, SUPPLY_CSR_IDX, 2'h0};

   // field positions
   localparam int AUX_IRQ_EN_BIT = 0;
   localparam int AUX_FLAG_BIT = 1;
   localparam int LV_RESET_FLAG_BIT = 2;
   localparam int PLL_LOCK_BIT = 3;

   localparam logic [CSR_W-1:0] CSR_RESET = 8'h00;
   localparam logic [APB_DW-1:0] RDATA_ZERO = 32'h0000_0000;

   // supply-monitor interrupt vector
   localparam logic [3:0] SUPPLY_IRQ_NUM = 4'h7;
   localparam logic [15:0] SUPPLY_IRQ_VECTOR = 16'hFFEC;

   typedef enum logic [1:0] {
      LEVEL_LOW = 2'h0,
      LEVEL_MEDIUM = 2'h1,
      LEVEL_HIGH = 2'h2
   } lvd_level_e;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'h1,
      BUS_DONE = 2'h2
   } bus_state_e;

endpackage

// >>> verilog/supply_integrity_monitor.sv
// supply integrity monitor: low-voltage reset hold, low-voltage reset flag,
// auxiliary voltage warning flag and interrupt, pll lock flag, one csr on apb.
// assumes comparator, pll lock and option inputs are asynchronous; cpu mode,
// mask, acknowledge and illegal-code inputs come from logic on clk_i.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module supply_integrity_monitor
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [supply_integrity_pkg::APB_AW-1:0] paddr_i,
   input wire logic [supply_integrity_pkg::APB_DW-1:0] pwdata_i,
   output logic [supply_integrity_pkg::APB_DW-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic lv_below_i,
   input wire logic aux_below_i,
   input wire logic pll_locked_i,
   input wire logic lvd_enable_opt_i,
   input wire logic [1:0] lvd_level_opt_i,
   output logic [1:0] lvd_level_o,
   input wire logic illegal_code_i,
   input wire logic cpu_halt_i,
   input wire logic cpu_wait_i,
   input wire logic int_mask_i,
   input wire logic aux_irq_ack_i,
   output logic system_reset_o,
   input wire logic reset_pin_i,
   output logic reset_pin_o,
   output logic reset_pin_oe_n_o,
   output logic watchdog_flag_clear_o,
   output logic aux_irq_o,
   output logic [3:0] aux_irq_num_o,
   output logic [15:0] aux_irq_vector_o,
   output logic wake_o
);
   import supply_integrity_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // synchronisers
   logic [1:0] lv_sync_ff, aux_sync_ff, pll_sync_ff, en_sync_ff;
   logic [1:0] lvl0_sync_ff, lvl1_sync_ff;
   logic [1:0] pin_sync_ff;
   logic lv_now, aux_now, pll_now, lvd_en;
   logic lv_prev_ff, aux_prev_ff;

   // first stage feeds only the second stage
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lv_sync_ff <= 2'h0;
         aux_sync_ff <= 2'h0;
         pll_sync_ff <= 2'h0;
         en_sync_ff <= 2'h0;
         lvl0_sync_ff <= 2'h0;
         lvl1_sync_ff <= 2'h0;
         pin_sync_ff <= 2'h3;
      end else begin
         lv_sync_ff <= {lv_sync_ff[0], lv_below_i};
         aux_sync_ff <= {aux_sync_ff[0], aux_below_i};
         pll_sync_ff <= {pll_sync_ff[0], pll_locked_i};
         en_sync_ff <= {en_sync_ff[0], lvd_enable_opt_i};
         lvl0_sync_ff <= {lvl0_sync_ff[0], lvd_level_opt_i[0]};
         lvl1_sync_ff <= {lvl1_sync_ff[0], lvd_level_opt_i[1]};
         pin_sync_ff <= {pin_sync_ff[0], reset_pin_i};
      end
   end

   assign lvd_en = en_sync_ff[1];
   assign lv_now = lv_sync_ff[1] & lvd_en;
   assign aux_now = aux_sync_ff[1] & lvd_en;
   assign pll_now = pll_sync_ff[1];

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lv_prev_ff <= 1'b0;
         aux_prev_ff <= 1'b0;
      end else begin
         lv_prev_ff <= lv_now;
         aux_prev_ff <= aux_now;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // threshold level option; an unused code falls back to the low level.
   // the two option bits are synchronised apart, so a code is taken only once
   // it has stood for two samples and a skewed change never shows a third code
   logic [1:0] lvl_code, lvl_prev_ff;

   assign lvl_code = {lvl1_sync_ff[1], lvl0_sync_ff[1]};

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lvl_prev_ff <= 2'h0;
      end else begin
         lvl_prev_ff <= lvl_code;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lvd_level_o <= LEVEL_LOW;
      end else if (lvl_code != lvl_prev_ff) begin
         lvd_level_o <= lvd_level_o;
      end else if (lvl_code == LEVEL_HIGH) begin
         lvd_level_o <= LEVEL_HIGH;
      end else if (lvl_code == LEVEL_MEDIUM) begin
         lvd_level_o <= LEVEL_MEDIUM;
      end else begin
         lvd_level_o <= LEVEL_LOW;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reset outputs; the reset pin is sampled only to tell a held board reset
   // apart, the block never releases another party's low level

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         system_reset_o <= 1'b0;
         reset_pin_o <= 1'b1;
         reset_pin_oe_n_o <= 1'b1;
         watchdog_flag_clear_o <= 1'b0;
      end else begin
         system_reset_o <= lv_now | illegal_code_i;
         reset_pin_o <= 1'b0;
         reset_pin_oe_n_o <= ~lv_now;
         watchdog_flag_clear_o <= lv_now & ~lv_prev_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, write and read data at the completing edge
   bus_state_e bus_ff;
   logic access, hit, wr_done;
   logic [CSR_W-1:0] csr_view;

   assign access = psel_i & penable_i;
   assign hit = (paddr_i == SUPPLY_CSR_ADDR);
   assign wr_done = access & pready_o & pwrite_i & hit;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bus_ff <= BUS_IDLE;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= RDATA_ZERO;
      end else begin
         case (bus_ff)
            BUS_IDLE: begin
               if (access) begin
                  bus_ff <= BUS_DONE;
                  pready_o <= 1'b1;
                  pslverr_o <= ~hit;
                  if (hit && !pwrite_i) begin
                     prdata_o <= {{(APB_DW-CSR_W){1'b0}}, csr_view};
                  end else begin
                     prdata_o <= RDATA_ZERO;
                  end
               end
            end
            default: begin
               bus_ff <= BUS_IDLE;
               pready_o <= 1'b0;
               pslverr_o <= 1'b0;
               prdata_o <= RDATA_ZERO;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control/status fields; halt freezes every field
   logic irq_en_ff, aux_flag_ff, lv_flag_ff, pll_flag_ff, pending_ff;
   logic aux_edge;

   // a disabled detector must not leave a pending crossing behind
   assign aux_edge = (aux_now ^ aux_prev_ff) & lvd_en;
   assign csr_view = {4'h0, pll_flag_ff, lv_flag_ff, aux_flag_ff, irq_en_ff};

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_en_ff <= CSR_RESET[AUX_IRQ_EN_BIT];
      end else if (wr_done && !cpu_halt_i) begin
         irq_en_ff <= pwdata_i[AUX_IRQ_EN_BIT];
      end
   end

   // with the detector off by option the flag carries no meaning; it resets
   // to zero so that software always reads a defined value
   // set wins over a software clear in the same cycle; only the block's
   // own power-on reset touches it, board and watchdog resets do not
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lv_flag_ff <= CSR_RESET[LV_RESET_FLAG_BIT];
      end else if (!cpu_halt_i) begin
         if (lv_now) begin
            lv_flag_ff <= 1'b1;
         end else if (wr_done && !pwdata_i[LV_RESET_FLAG_BIT]) begin
            lv_flag_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         aux_flag_ff <= CSR_RESET[AUX_FLAG_BIT];
         pll_flag_ff <= CSR_RESET[PLL_LOCK_BIT];
      end else if (!cpu_halt_i) begin
         aux_flag_ff <= aux_now;
         pll_flag_ff <= pll_now;
      end
   end

   // the comparator stays active in halt, so crossings still latch
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pending_ff <= 1'b0;
      end else if (aux_edge) begin
         pending_ff <= 1'b1;
      end else if (aux_irq_ack_i || !lvd_en) begin
         pending_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt request and wake
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         aux_irq_o <= 1'b0;
         wake_o <= 1'b0;
         aux_irq_num_o <= 4'h0;
         aux_irq_vector_o <= 16'h0000;
      end else begin
         aux_irq_o <= pending_ff & irq_en_ff & ~int_mask_i & ~aux_irq_ack_i;
         wake_o <= pending_ff & irq_en_ff & cpu_wait_i & ~cpu_halt_i;
         aux_irq_num_o <= SUPPLY_IRQ_NUM;
         aux_irq_vector_o <= SUPPLY_IRQ_VECTOR;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   a_lv_reset_hold: assert property (lv_now |=> system_reset_o)
      else $error("system reset not held during low supply");
   a_pin_drive_low: assert property (lv_now |=> !reset_pin_oe_n_o && !reset_pin_o)
      else $error("reset pin not driven during low supply");
   a_lv_flag_set: assert property (lv_now && !cpu_halt_i |=> lv_flag_ff)
      else $error("low-voltage flag not set");
   a_lv_flag_hold: assert property (lv_flag_ff && !wr_done |=> lv_flag_ff)
      else $error("low-voltage flag lost without software clear");
   a_wdg_clear_pulse: assert property ($rose(lv_now) |=> watchdog_flag_clear_o)
      else $error("watchdog flag clear missing");
   a_illegal_reset: assert property (illegal_code_i |=> system_reset_o)
      else $error("illegal code did not reset");
   a_aux_follow: assert property (!cpu_halt_i |=> aux_flag_ff == $past(aux_now))
      else $error("aux flag does not follow comparator");
   a_aux_disabled: assert property (!lvd_en |=> !pending_ff)
      else $error("aux pending while detector disabled");
   a_aux_crossing: assert property (lvd_en && aux_now != aux_prev_ff |=> pending_ff)
      else $error("crossing did not latch pending");
   a_irq_gating: assert property (aux_irq_o |-> $past(irq_en_ff && !int_mask_i))
      else $error("interrupt requested while gated");
   a_irq_ack_clear: assert property (aux_irq_ack_i && !aux_edge |=> !pending_ff)
      else $error("pending not cleared on acknowledge");
   a_halt_freeze: assert property (cpu_halt_i |=> $stable(csr_view))
      else $error("register changed in halt");
   a_no_halt_wake: assert property (cpu_halt_i |=> !wake_o)
      else $error("wake raised in halt");
   a_pll_flag: assert property (!cpu_halt_i |=> pll_flag_ff == $past(pll_now))
      else $error("pll flag wrong");
   a_reserved_zero: assert property (pready_o |-> prdata_o[APB_DW-1:4] == 28'h0)
      else $error("reserved bits read nonzero");
   a_bus_one_wait: assert property (access && !pready_o |=> pready_o ##1 !pready_o)
      else $error("bus answer timing wrong");

   // supply and reset checks
   a_pin_idle_high: assert property (!lv_now |=> reset_pin_oe_n_o)
      else $error("reset pin driven without low supply");
   a_reset_release: assert property (!lv_now && !illegal_code_i |=> !system_reset_o)
      else $error("system reset held without cause");
   a_lv_flag_clear: assert property (wr_done && !pwdata_i[LV_RESET_FLAG_BIT] && !lv_now
      && !cpu_halt_i |=> !lv_flag_ff)
      else $error("low-voltage flag not cleared by software");
   a_wdg_clear_once: assert property (watchdog_flag_clear_o |=> !watchdog_flag_clear_o)
      else $error("watchdog flag clear longer than one cycle");
   a_lv_disabled: assert property (!lvd_en && !illegal_code_i |=> !system_reset_o)
      else $error("reset raised with detector disabled");
   a_level_high: assert property (lvl_code == LEVEL_HIGH && lvl_prev_ff == LEVEL_HIGH
      |=> lvd_level_o == LEVEL_HIGH)
      else $error("high level option not applied");
   a_level_medium: assert property (lvl_code == LEVEL_MEDIUM && lvl_prev_ff == LEVEL_MEDIUM
      |=> lvd_level_o == LEVEL_MEDIUM)
      else $error("medium level option not applied");
   a_level_fallback: assert property (lvl_code == lvl_prev_ff && lvl_code != LEVEL_HIGH
      && lvl_code != LEVEL_MEDIUM |=> lvd_level_o == LEVEL_LOW)
      else $error("low level option not applied");

   // bus checks
   a_unmapped_error: assert property (access && !pready_o && !hit |=> pready_o && pslverr_o)
      else $error("unmapped access without error");
   a_read_data: assert property (access && !pready_o && hit && !pwrite_i
      |=> prdata_o[CSR_W-1:0] == $past(csr_view))
      else $error("read data does not match register");
   a_bus_idle_zero: assert property (!pready_o |-> prdata_o == RDATA_ZERO && !pslverr_o)
      else $error("bus outputs not zero between transfers");
   a_halt_no_write: assert property (cpu_halt_i && wr_done |=> $stable(irq_en_ff))
      else $error("write accepted in halt");

   // interrupt and mode checks
   a_irq_request: assert property (pending_ff && irq_en_ff && !int_mask_i && !aux_irq_ack_i
      |=> aux_irq_o)
      else $error("interrupt not requested");
   a_wait_wake: assert property (pending_ff && irq_en_ff && cpu_wait_i && !cpu_halt_i
      |=> wake_o)
      else $error("wake missing in wait");
   a_pending_hold: assert property (pending_ff && !aux_irq_ack_i && lvd_en |=> pending_ff)
      else $error("pending lost without acknowledge");
   a_ack_drop: assert property (aux_irq_ack_i |=> !aux_irq_o)
      else $error("request kept after acknowledge");
   a_irq_vector: assert property (aux_irq_o |-> aux_irq_num_o == SUPPLY_IRQ_NUM
      && aux_irq_vector_o == SUPPLY_IRQ_VECTOR)
      else $error("wrong interrupt vector");

   c_low_supply: cover property ($rose(lv_now) ##[1:20] $fell(lv_now));
   c_irq_served: cover property (aux_irq_o ##[1:10] aux_irq_ack_i);
   c_flag_cleared: cover property (lv_flag_ff ##1 !lv_flag_ff);
   c_wait_wake: cover property (cpu_wait_i && wake_o);
   c_pin_pulled: cover property (!reset_pin_oe_n_o && !pin_sync_ff[1]);

endmodule

// >>> dv/supply_sense_model.sv
// analog side of the supply monitor: two supply comparators and a pll lock detector.
// assumes the bench sets a supply code; threshold codes are plain defaults.
`timescale 1ns/1ps
module supply_sense_model #(
   parameter int LV_TH = 40,
   parameter int AUX_TH = 60,
   parameter int LOCK_CYCLES = 20
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [7:0] supply_i,
   input wire logic [1:0] lvd_level_i,
   input wire logic pll_on_i,
   output logic lv_below_o,
   output logic aux_below_o,
   output logic pll_locked_o
);
   int lock_cnt;
   ////////////////////////////////////////////////////////////////////////////////
   // both thresholds climb with the level code; no hysteresis, kept simple
   always_comb begin
      lv_below_o = int'(supply_i) < LV_TH + 8 * int'(lvd_level_i);
      aux_below_o = int'(supply_i) < AUX_TH + 8 * int'(lvd_level_i);
   end
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lock_cnt <= 0;
      end else if (!pll_on_i) begin
         lock_cnt <= 0;
      end else if (lock_cnt < LOCK_CYCLES) begin
         lock_cnt <= lock_cnt + 1;
      end
   end
   assign pll_locked_o = (lock_cnt == LOCK_CYCLES);
endmodule

// >>> dv/supply_integrity_monitor_bench.sv
// testbench for the supply integrity monitor: csr over apb, low-voltage reset,
// auxiliary warning interrupt, wait and halt, pll lock, illegal code reset.
// assumes supply_sense_model on the analog pins and a 10 MHz clock.
`timescale 1ns/1ps
module supply_integrity_monitor_bench;
   import supply_integrity_pkg::*;
   localparam int LOCK = 20;
   localparam logic [11:0] CSR = SUPPLY_CSR_ADDR;
   logic clk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
   logic lv_below_i, aux_below_i, pll_locked_i, lvd_enable_opt_i = 1, illegal_code_i = 0;
   logic cpu_halt_i = 0, cpu_wait_i = 0, int_mask_i = 0, aux_irq_ack_i = 0;
   logic reset_pin_i, reset_pin_o;
   logic [1:0] lvd_level_opt_i = 2'h0, lvd_level_o;
   logic pready_o, pslverr_o, system_reset_o, reset_pin_oe_n_o, watchdog_flag_clear_o;
   logic aux_irq_o, wake_o, err, pll_on = 0;
   logic [3:0] aux_irq_num_o;
   logic [15:0] aux_irq_vector_o;
   logic [7:0] supply = 8'hC8;
   int bad_count = 0, checks = 0, n;

   supply_integrity_monitor DUT (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .lv_below_i, .aux_below_i, .pll_locked_i,
      .lvd_enable_opt_i, .lvd_level_opt_i, .lvd_level_o, .illegal_code_i, .cpu_halt_i,
      .cpu_wait_i, .int_mask_i, .aux_irq_ack_i, .system_reset_o, .reset_pin_i,
      .reset_pin_o, .reset_pin_oe_n_o, .watchdog_flag_clear_o, .aux_irq_o, .aux_irq_num_o,
      .aux_irq_vector_o, .wake_o);
   supply_sense_model #(.LOCK_CYCLES(LOCK)) SENSE (.clk_i, .rstn_i, .supply_i(supply),
      .lvd_level_i(lvd_level_o), .pll_on_i(pll_on), .lv_below_o(lv_below_i),
      .aux_below_o(aux_below_i), .pll_locked_o(pll_locked_i));

   // open-drain board reset line with its pull-up
   assign reset_pin_i = reset_pin_oe_n_o ? 1'b1 : reset_pin_o;

   always #50 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic bchk(input logic got, input logic exp, input string what);
      chk({31'h0, got}, {31'h0, exp}, what);
   endtask
   // request held until the edge that samples pready high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= wd;
      cyc(1);
      penable_i <= 1'b1;
      cyc(1);
      while (pready_o !== 1'b1 && k < 20) begin
         cyc(1);
         k++;
      end
      if (k == 20) chk(32'h0, 32'h1, "no pready");
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      cyc(1);
   endtask
   task automatic rchk(input logic [31:0] exp, input string what);
      apb(1'b0, CSR, 32'h0);
      chk(rd, exp, what);
   endtask
   task automatic ack;
      aux_irq_ack_i <= 1'b1;
      cyc(1);
      aux_irq_ack_i <= 1'b0;
      cyc(3);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rchk(32'h0, "csr reset");
      apb(1'b1, CSR + 12'h004, 32'h1);
      bchk(err, 1'b1, "unmapped err");
      rchk(32'h0, "unmapped write leaked");
      chk({16'h0, aux_irq_vector_o}, 32'hFFEC, "vector");
      chk({28'h0, aux_irq_num_o}, 32'h7, "vector num");
      for (int l = 0; l < 3; l++) begin
         lvd_level_opt_i <= l[1:0];
         cyc(5);
         chk({30'h0, lvd_level_o}, l, "level");
      end
      lvd_level_opt_i <= 2'h0;
      cyc(5);
   endtask
   task automatic t_pll;
      pll_on <= 1'b1;
      cyc(LOCK + 8);
      rchk(32'h8, "pll locked");
      apb(1'b1, CSR, 32'h0);
      rchk(32'h8, "pll bit writable");
      pll_on <= 1'b0;
      cyc(5);
      rchk(32'h0, "pll unlock");
   endtask
   task automatic t_lvd;
      supply <= 8'h1E;
      n = 0;
      repeat (8) begin
         @(posedge clk_i);
         if (watchdog_flag_clear_o === 1'b1) n++;
      end
      chk(n, 1, "wdg clear pulses");
      chk({30'h0, system_reset_o, reset_pin_oe_n_o}, 32'h2, "lv reset");
      bchk(reset_pin_i, 1'b0, "board reset pin low");
      supply <= 8'hC8;
      cyc(5);
      bchk(system_reset_o, 1'b0, "reset release");
      bchk(reset_pin_i, 1'b1, "board reset pin released");
      apb(1'b1, CSR, 32'h4);
      rchk(32'h4, "lv flag");
      apb(1'b1, CSR, 32'h0);
      rchk(32'h0, "lv flag clear");
   endtask
   task automatic t_aux;
      ack();
      apb(1'b1, CSR, 32'h1);
      bchk(aux_irq_o, 1'b0, "irq no event");
      supply <= 8'h32;
      cyc(6);
      bchk(aux_irq_o, 1'b1, "falling irq");
      rchk(32'h3, "aux flag");
      ack();
      bchk(aux_irq_o, 1'b0, "ack clear");
      int_mask_i <= 1'b1;
      supply <= 8'hC8;
      cyc(6);
      bchk(aux_irq_o, 1'b0, "masked irq");
      int_mask_i <= 1'b0;
      cyc(3);
      bchk(aux_irq_o, 1'b1, "rising irq");
      ack();
   endtask
   task automatic t_modes;
      cpu_wait_i <= 1'b1;
      supply <= 8'h32;
      cyc(6);
      bchk(wake_o, 1'b1, "wait wake");
      ack();
      cpu_halt_i <= 1'b1;
      supply <= 8'hC8;
      cyc(6);
      bchk(wake_o, 1'b0, "halt wake");
      apb(1'b1, CSR, 32'h0);
      rchk(32'h3, "halt frozen");
      cpu_halt_i <= 1'b0;
      cyc(3);
      bchk(wake_o, 1'b1, "pending kept");
      cpu_wait_i <= 1'b0;
      ack();
   endtask
   task automatic t_misc;
      lvd_enable_opt_i <= 1'b0;
      cyc(4);
      supply <= 8'h1E;
      cyc(6);
      chk({30'h0, system_reset_o, aux_irq_o}, 32'h0, "detector off");
      apb(1'b0, CSR, 32'h0);
      chk(rd & 32'h2, 32'h0, "aux flag off");
      supply <= 8'hC8;
      lvd_enable_opt_i <= 1'b1;
      cyc(5);
      illegal_code_i <= 1'b1;
      cyc(1);
      illegal_code_i <= 1'b0;
      n = 0;
      repeat (4) begin
         @(posedge clk_i);
         if (system_reset_o === 1'b1) n++;
      end
      chk(n, 1, "illegal code reset");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #(100 * 20000);
      bad_count++;
      final_report();
   end
   initial begin
      cyc(2);
      rstn_i <= 1'b1;
      cyc(2);
      t_regs();
      t_pll();
      t_lvd();
      t_aux();
      t_modes();
      t_misc();
      final_report();
   end
endmodule
